// File: hw/pcs_sequencer.sv
// Panel phase sequencer running the clear-memory and load (fill) sequences.
// Assumes panel switches are asynchronous pins; memory and strobe inputs are on clk_i.
// Assumes memory answers every held data request with a data release in bounded time.
// Assumes mem_size_words_i is nonzero and stays fixed while a clear runs.
module pcs_sequencer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire pcs_pkg::pcs_switch_s sw_i,
    input wire logic mem_data_release_i,
    input wire logic [31:0] mem_read_data_i,
    input wire logic function_strobe_i,
    input wire logic [31:0] mem_size_words_i,
    output pcs_pkg::pcs_mem_s mem_o,
    output logic [31:0] display_o,
    output logic [31:0] pc_o,
    output logic [31:0] instr_o,
    output logic halt_o,
    output logic io_service_call_o,
    output logic interrupt_entry_set_o,
    output logic [2:0] phase_o,
    output logic [1:0] adder_sel_o
);
    // Three-stage synchronisers for the five panel switches.
    // Stage one may go metastable, so only stages two and three are compared;
    // a switch that bounces within one clock is never taken.
    logic [4:0] sync1_reg, sync2_reg, sync3_reg, sw_reg; // Chain and agreed value.
    logic [4:0] sw_next; // Agreed switch word for the next clock.
    pcs_pkg::pcs_switch_s swv; // Agreed switches viewed by field.

    // Sequencer state.
    // A, B and D stand for the processor registers that the panel phases move.
    // D doubles as the instruction register shown on instr_o.
    // mode_fill_reg tells a load from a clear once the common first phases are left.
    pcs_pkg::pcs_phase_e phase_reg, phase_next;
    pcs_pkg::pcs_sum_e sum_reg, sum_next;
    logic [31:0] a_reg, a_next, b_reg, b_next, d_reg, d_next, pc_reg, pc_next;
    logic halt_reg, halt_next, io_service_call_ff_reg, io_service_call_ff_next, mode_fill_reg, mode_fill_next;
    pcs_pkg::pcs_mem_s mem_reg, mem_next;
    logic [31:0] display_reg, display_next;

    // Sum bus value chosen by the preset adder selection.
    // The selection is registered one phase ahead, as the adder presets work.
    function automatic logic [31:0] sum_bus(input pcs_pkg::pcs_sum_e sel,
                                            input logic [31:0] a, input logic [31:0] b,
                                            input logic [31:0] d);
        case (sel)
            pcs_pkg::SUM_FROM_A: sum_bus = a;
            pcs_pkg::SUM_FROM_B: sum_bus = b;
            default: sum_bus = d;
        endcase
    endfunction

    // Switch synchroniser: a change counts once stages two and three agree.
    // Until they agree the last agreed value stands.
    always_comb begin
        sw_next = sw_reg;
        if (sync2_reg == sync3_reg) begin
            sw_next = sync3_reg;
        end
    end

    // Registers of the synchroniser chain.
    // Reset clears the chain, which reads as every switch released.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
            sw_reg <= 5'h00;
        end else begin
            sync1_reg <= sw_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            sw_reg <= sw_next;
        end
    end

    // The struct view lets the logic below name each switch.
    assign swv = pcs_pkg::pcs_switch_s'(sw_reg);

    // Phase sequencing and data path moves.
    // Decisions are taken from registered state, agreed switches and the clk_i memory and strobe inputs, so the
    // next values settle within one clock. While memory owes a data release the
    // whole case is skipped, which stands for the clock being withheld.
    // The trade-off is that the panel cannot abort a stalled memory cycle.
    always_comb begin
        logic clear_cond; // Both reset switches held and address stop off.
        logic [31:0] s; // Sum bus as the preset adder shows it this clock.
        logic wait_mem; // Memory still owes the data release.
        logic repeat_phase_five_branch; // Phase five runs once more after this pass.
        logic [31:0] pc_inc; // Program counter plus one.
        logic [31:0] pc_wrap; // Next counter value, folded at the memory size in a clear.
        clear_cond = swv.cpu_reset & swv.sys_reset & ~swv.address_stop;
        s = sum_bus(sum_reg, a_reg, b_reg, d_reg);
        wait_mem = mem_reg.data_request & ~mem_data_release_i;
        repeat_phase_five_branch = clear_cond;
        if (mode_fill_reg) begin
            repeat_phase_five_branch = swv.fill && (pc_reg != pcs_pkg::LAST_BOOT_ADDR);
        end
        pc_inc = pc_reg + pcs_pkg::PC_STEP;
        // A clear folds the counter at the memory size so a small memory is fully covered;
        // a load never folds, since its bootstrap area sits at fixed low addresses.
        pc_wrap = pc_inc;
        if (!mode_fill_reg && !(pc_inc < mem_size_words_i)) begin
            pc_wrap = pcs_pkg::ZERO_WORD;
        end
        phase_next = phase_reg;
        sum_next = sum_reg;
        a_next = a_reg;
        b_next = b_reg;
        d_next = d_reg;
        pc_next = pc_reg;
        halt_next = halt_reg;
        io_service_call_ff_next = io_service_call_ff_reg;
        mode_fill_next = mode_fill_reg;
        mem_next = mem_reg;
        display_next = display_reg;
        // Memory handshake ends on data release.
        if (mem_reg.data_request && mem_data_release_i) begin
            mem_next.mem_request = 1'b0;
            mem_next.data_request = 1'b0;
            mem_next.bus_select = 1'b0;
        end
        // No clock is sent onward while memory holds data request.
        // stall for release
        if (!wait_mem) begin
            case (phase_reg)
                pcs_pkg::panel_phase_two: begin
                    // Idle phase: the sum bus shows D on the display, and a panel
                    // action starts a sequence. The adder is preset for D in
                    // phase three whichever sequence starts.
                    // idle display path
                    display_next = s;
                    if (!swv.address_stop) begin
                        halt_next = 1'b0;
                    end
                    if (clear_cond) begin
                        // Clear wins over fill when both are pressed.
                        mode_fill_next = 1'b0;
                        phase_next = pcs_pkg::panel_phase_three;
                        sum_next = pcs_pkg::SUM_FROM_D;
                    end else if (swv.fill) begin
                        // A load runs the same first phases as a clear.
                        mode_fill_next = 1'b1;
                        phase_next = pcs_pkg::panel_phase_three;
                        sum_next = pcs_pkg::SUM_FROM_D;
                    end else if (swv.run && halt_reg == 1'b0 && mode_fill_reg) begin
                        // Run is honoured only after a load whose halt was reset.
                        phase_next = pcs_pkg::exec_phase_ten;
                    end
                end
                pcs_pkg::panel_phase_three: begin
                    // One clock long: save the next instruction, zero A and
                    // preset the adder for A so that phase four clears D.
                    // The service call is dropped here unless a strobe holds it.
                    // save instruction in B
                    b_next = s;
                    if (!function_strobe_i) begin
                        io_service_call_ff_next = 1'b0;
                    end
                    a_next = pcs_pkg::ZERO_WORD;
                    sum_next = pcs_pkg::SUM_FROM_A;
                    phase_next = pcs_pkg::panel_phase_four;
                end
                pcs_pkg::panel_phase_four: begin
                    // Zeros from A clear D before the write loop.
                    // The request raised here is held until memory sends data release,
                    // and the sequencer takes no further step meanwhile.
                    d_next = s;
                    mem_next.bus_select = 1'b1;
                    mem_next.mem_request = 1'b1;
                    mem_next.data_request = 1'b1;
                    mem_next.addr = pc_reg;
                    mem_next.data = s;
                    sum_next = pcs_pkg::SUM_FROM_A;
                    phase_next = pcs_pkg::panel_phase_five;
                end
                pcs_pkg::panel_phase_five: begin
                    // Each pass ends on a data release; the loop decision is made above.
                    // step program counter
                    pc_next = pc_wrap;
                    // A load takes the returned word into B on every pass.
                    if (mode_fill_reg) begin
                        b_next = mem_read_data_i;
                    end
                    if (repeat_phase_five_branch) begin
                        sum_next = pcs_pkg::SUM_FROM_A;
                        mem_next.bus_select = 1'b1;
                        mem_next.mem_request = 1'b1;
                        mem_next.data_request = 1'b1;
                        // The next write goes to the word that the counter now names.
                        // In a clear that word has already been folded into the memory.
                        mem_next.addr = pc_wrap;
                        mem_next.data = mode_fill_reg ? mem_read_data_i : s;
                    end else begin
                        // Last pass: in a clear B brings the saved word back in phase six; in a load B holds the last word read.
                        // preset B final
                        sum_next = pcs_pkg::SUM_FROM_B;
                        phase_next = pcs_pkg::panel_phase_six;
                    end
                end
                pcs_pkg::panel_phase_six: begin
                    // One clock long: D is restored from B and the machine halts.
                    // A load then overrides D and the counter so that run starts
                    // the bootstrap with a harmless instruction.
                    // restore D, halt
                    d_next = s;
                    halt_next = 1'b1;
                    if (mode_fill_reg) begin
                        pc_next = pcs_pkg::LOAD_PC_VALUE;
                        d_next = pcs_pkg::NOP_INSTR;
                    end
                    sum_next = pcs_pkg::SUM_FROM_D;
                    phase_next = pcs_pkg::panel_phase_one;
                end
                pcs_pkg::panel_phase_one: begin
                    // One clock long, only to preset the adder for the idle display.
                    // preset D path
                    sum_next = pcs_pkg::SUM_FROM_D;
                    phase_next = pcs_pkg::panel_phase_two;
                end
                pcs_pkg::exec_phase_ten: begin
                    // Stands for the run start after a load: one step of the counter,
                    // then back to idle. Clearing the load mode stops a second step
                    // while the run switch stays up.
                    // add one on run
                    pc_next = pc_reg + pcs_pkg::PC_STEP;
                    mode_fill_next = 1'b0;
                    phase_next = pcs_pkg::panel_phase_two;
                end
                default: begin
                    // An unused phase code falls back to phase one.
                    // This only matters after an upset, since no path leads there.
                    phase_next = pcs_pkg::panel_phase_one;
                end
            endcase
        end
        // A function strobe sets the service call in any phase. When it meets the
        // phase-three clear in the same clock, the set wins.
        if (function_strobe_i) begin
            io_service_call_ff_next = 1'b1;
        end
    end

    // Registers of the sequencer and data path.
    // This process only registers the next values; all decisions sit above.
    // Reset leaves the machine halted in phase one, which then falls to idle.
    // Memory requests drop at reset, so a cut memory cycle is simply abandoned.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_reg <= pcs_pkg::panel_phase_one;
            sum_reg <= pcs_pkg::SUM_FROM_D;
            a_reg <= pcs_pkg::ZERO_WORD;
            b_reg <= pcs_pkg::ZERO_WORD;
            d_reg <= pcs_pkg::ZERO_WORD;
            pc_reg <= pcs_pkg::ZERO_WORD;
            halt_reg <= 1'b1;
            io_service_call_ff_reg <= 1'b0;
            mode_fill_reg <= 1'b0;
            mem_reg <= '0;
            display_reg <= pcs_pkg::ZERO_WORD;
        end else begin
            phase_reg <= phase_next;
            sum_reg <= sum_next;
            a_reg <= a_next;
            b_reg <= b_next;
            d_reg <= d_next;
            pc_reg <= pc_next;
            halt_reg <= halt_next;
            io_service_call_ff_reg <= io_service_call_ff_next;
            mode_fill_reg <= mode_fill_next;
            mem_reg <= mem_next;
            display_reg <= display_next;
        end
    end

    // Interrupt entry is blocked in idle phase two while run is off.
    // interrupt block idle
    assign interrupt_entry_set_o = ~((phase_reg == pcs_pkg::panel_phase_two) & ~swv.run);
    // Data outputs come straight from flip-flops, so the panel and memory see
    // values that change only on clock edges. Only the interrupt block above is
    // combinational, since it acts as a handshake term.
    // The phase and adder selection are exported for the panel lamps.
    assign mem_o = mem_reg;
    assign display_o = display_reg;
    assign pc_o = pc_reg;
    assign instr_o = d_reg;
    assign halt_o = halt_reg;
    assign io_service_call_o = io_service_call_ff_reg;
    assign phase_o = phase_reg;
    assign adder_sel_o = sum_reg;
endmodule

// File: hw/pcs_pkg.sv
// Package for the panel clear-and-load phase sequencer: phases, constants, carriers.
// Assumes one 25 MHz clock and a synchronous active-high reset in the user.
package pcs_pkg;
    // Data path width of the processor registers.
    localparam int DW = 32;
    // Last bootstrap location reached by the load loop.
    localparam logic [31:0] LAST_BOOT_ADDR = 32'h0000_0029;
    // Program counter value forced at the end of a load.
    localparam logic [31:0] LOAD_PC_VALUE = 32'h0000_0025;
    // No-operation instruction forced into the instruction register.
    localparam logic [31:0] NOP_INSTR = 32'h0200_0000;
    // Counter increment step.
    localparam logic [31:0] PC_STEP = 32'h0000_0001;
    // All-zero word for clearing memory.
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Panel phases; exec_ten stands for the run start after a load.
    typedef enum logic [2:0] {
        panel_phase_one,
        panel_phase_two,
        panel_phase_three,
        panel_phase_four,
        panel_phase_five,
        panel_phase_six,
        exec_phase_ten
    } pcs_phase_e;

    // Adder source selection for the sum bus.
    typedef enum logic [1:0] {
        SUM_FROM_D,
        SUM_FROM_A,
        SUM_FROM_B
    } pcs_sum_e;

    // Operator panel switch group.
    typedef struct packed {
        logic cpu_reset;
        logic sys_reset;
        logic fill;
        logic run;
        logic address_stop;
    } pcs_switch_s;

    // Memory request group driven toward core memory.
    typedef struct packed {
        logic bus_select;
        logic mem_request;
        logic data_request;
        logic [31:0] addr;
        logic [31:0] data;
    } pcs_mem_s;
endpackage

// File: tb/pcs_sequencer_props.sv
// Checker for the panel sequencer: timing relations seen at its ports.
// Assumes the bench never lowers the run switch once it has raised it.
module pcs_sequencer_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire pcs_pkg::pcs_switch_s sw_i,
    input wire logic mem_data_release_i,
    input wire pcs_pkg::pcs_mem_s mem_o,
    input wire logic [31:0] pc_o,
    input wire logic [31:0] instr_o,
    input wire logic halt_o,
    input wire logic interrupt_entry_set_o,
    input wire logic [2:0] phase_o
);
    // One clock domain, so one clocking and one reset mute serve all.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_request_held: assert property (
        mem_o.data_request && !mem_data_release_i |=> mem_o.data_request && $stable(phase_o))
        else $error("request or phase moved before release");
    a_three_one_clock: assert property (
        phase_o == pcs_pkg::panel_phase_three |=> phase_o == pcs_pkg::panel_phase_four)
        else $error("phase three lasted more than one clock");
    a_halt_after_six: assert property (
        phase_o == pcs_pkg::panel_phase_six |=> halt_o) else $error("halt not set");
    a_idle_return: assert property (
        phase_o == pcs_pkg::panel_phase_six |=> phase_o == pcs_pkg::panel_phase_one
        ##1 phase_o == pcs_pkg::panel_phase_two) else $error("no return to idle");
    // The fill switch is let go near the end, so look back at it.
    a_load_end_values: assert property (
        phase_o == pcs_pkg::panel_phase_six && $past(sw_i.fill, 30) |=>
        pc_o == pcs_pkg::LOAD_PC_VALUE && instr_o == pcs_pkg::NOP_INSTR)
        else $error("load end values wrong");
    a_irq_outside_idle: assert property (
        phase_o != pcs_pkg::panel_phase_two |-> interrupt_entry_set_o)
        else $error("interrupt entry blocked outside idle");
    a_irq_blocked: assert property (
        phase_o == pcs_pkg::panel_phase_two && !sw_i.run |-> !interrupt_entry_set_o)
        else $error("interrupt entry open in idle");
    a_clear_zero_data: assert property (
        mem_o.data_request && sw_i.cpu_reset && sw_i.sys_reset |-> mem_o.data == 32'h0)
        else $error("clear wrote nonzero data");
    a_pc_step_one: assert property (
        sw_i.fill && $past(phase_o) == pcs_pkg::panel_phase_five && $changed(pc_o)
        |-> pc_o == $past(pc_o) + pcs_pkg::PC_STEP) else $error("counter step wrong");
endmodule
bind pcs_sequencer pcs_sequencer_props i_pcs_sequencer_props (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sw_i(sw_i), .mem_data_release_i(mem_data_release_i),
    .mem_o(mem_o), .pc_o(pc_o), .instr_o(instr_o), .halt_o(halt_o),
    .interrupt_entry_set_o(interrupt_entry_set_o), .phase_o(phase_o));

// File: tb/pcs_core_memory.sv
// Core memory model answering data requests after a chosen latency.
// Assumes requests are held until release, as the sequencer promises.
module pcs_core_memory (
    input wire logic clk_i,
    input wire pcs_pkg::pcs_mem_s mem_i,
    input wire logic [3:0] lat_i,
    output logic release_o,
    output logic [31:0] rdata_o
);
    logic [3:0] wait_reg; // Cycles the current request has waited.
    logic [31:0] last_reg; // Last word driven, inverted when idle.
    assign release_o = mem_i.data_request && (wait_reg >= lat_i);
    // Idle bus shows the inverse so a stale word never looks valid.
    assign rdata_o = mem_i.data_request ? {~mem_i.addr[15:0], mem_i.addr[15:0]} : ~last_reg;
    // Restart the count after each release so back-to-back passes wait too.
    always_ff @(posedge clk_i) begin
        if (!mem_i.data_request || release_o) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hF) begin
            wait_reg <= wait_reg + 4'h1;
        end
        last_reg <= rdata_o;
    end
endmodule

// File: tb/pcs_sequencer_bench.sv
// Self-checking bench: load, clear, slow load, then run.
// Assumes the core memory model and the checker are compiled alongside.
module pcs_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic function_strobe_i = 1'b0;
    logic mem_data_release_i;
    pcs_pkg::pcs_switch_s sw_i = '0;
    logic [31:0] mem_read_data_i;
    logic [31:0] mem_size_words_i = 32'h0000_0008; // Small memory keeps clear short.
    pcs_pkg::pcs_mem_s mem_o;
    logic [31:0] display_o, pc_o, instr_o;
    logic halt_o, io_service_call_o, interrupt_entry_set_o;
    logic [2:0] phase_o;
    logic [1:0] adder_sel_o;
    logic [3:0] lat_i = 4'h1; // Memory latency, changed per scenario.
    logic [15:0] hit_map = '0; // Addresses written with zeros.
    int err_count = 0;
    int n_tests = 0;
    always #20 clk_i = ~clk_i;
    pcs_sequencer i_pcs_sequencer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sw_i(sw_i),
        .mem_data_release_i(mem_data_release_i), .mem_read_data_i(mem_read_data_i),
        .function_strobe_i(function_strobe_i), .mem_size_words_i(mem_size_words_i),
        .mem_o(mem_o), .display_o(display_o), .pc_o(pc_o), .instr_o(instr_o),
        .halt_o(halt_o), .io_service_call_o(io_service_call_o),
        .interrupt_entry_set_o(interrupt_entry_set_o), .phase_o(phase_o),
        .adder_sel_o(adder_sel_o));
    pcs_core_memory i_pcs_core_memory (.clk_i(clk_i), .mem_i(mem_o), .lat_i(lat_i),
        .release_o(mem_data_release_i), .rdata_o(mem_read_data_i));
    // Note every completed zero write in the low address range.
    always @(posedge clk_i) begin
        if (mem_o.data_request && mem_data_release_i && mem_o.data === 32'h0
            && mem_o.addr < 32'h10) begin
            hit_map[mem_o.addr[3:0]] <= 1'b1;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait for a phase; a miss counts as a mismatch.
    task wait_phase(input logic [2:0] p);
        for (int i = 0; i < 3000 && phase_o !== p; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({29'h0, phase_o}, {29'h0, p});
    endtask
    // Fill must be let go before idle, or the sequencer would start again.
    task do_load(input logic strobe, input logic [3:0] lat);
        @(posedge clk_i);
        lat_i <= lat;
        function_strobe_i <= strobe;
        sw_i.fill <= 1'b1;
        wait_phase(pcs_pkg::panel_phase_three);
        for (int i = 0; i < 3000 && pc_o < 32'h28; i++) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        sw_i.fill <= 1'b0;
        wait_phase(pcs_pkg::panel_phase_six);
        @(posedge clk_i);
        #1;
        chk(pc_o, 32'h0000_0025);
        chk(instr_o, 32'h0200_0000);
        chk({31'h0, halt_o}, 32'h1);
        chk({31'h0, io_service_call_o}, {31'h0, strobe});
        wait_phase(pcs_pkg::panel_phase_two);
        @(posedge clk_i);
        function_strobe_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk({31'h0, halt_o}, 32'h0);
        chk({31'h0, interrupt_entry_set_o}, 32'h0);
        chk(display_o, 32'h0200_0000);
    endtask
    task do_clear;
        @(posedge clk_i);
        lat_i <= 4'h3;
        hit_map <= '0;
        sw_i.cpu_reset <= 1'b1;
        sw_i.sys_reset <= 1'b1;
        wait_phase(pcs_pkg::panel_phase_five);
        chk({30'h0, adder_sel_o}, 32'h1);
        repeat (150) @(posedge clk_i);
        sw_i.cpu_reset <= 1'b0;
        sw_i.sys_reset <= 1'b0;
        wait_phase(pcs_pkg::panel_phase_six);
        chk({30'h0, adder_sel_o}, 32'h2);
        @(posedge clk_i);
        #1;
        chk({31'h0, halt_o}, 32'h1);
        chk({31'h0, io_service_call_o}, 32'h0);
        chk(instr_o, 32'h0200_0000);
        chk({16'h0, hit_map}, 32'h0000_00FF);
        wait_phase(pcs_pkg::panel_phase_two);
    endtask
    task do_run;
        @(posedge clk_i);
        sw_i.run <= 1'b1;
        repeat (12) @(posedge clk_i);
        #1;
        chk(pc_o, 32'h0000_0026);
    endtask
    // Cut a hang short well beyond the expected run length.
    initial begin
        #(40 * 40000);
        err_count++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        do_load(1'b1, 4'h1);
        do_clear();
        do_load(1'b0, 4'h5);
        do_run();
        summarize();
    end
endmodule
